// ===== verilog/sswd_top.sv
// Notes on behaviour
// RULE_01: A start on the bus later followed by a stop restarts the watchdog.
// RULE_02: With no restart before the chosen interval ends, timeout asserts.
// RULE_03: The interval is 25 ms, 200 ms, 1.4 s, or the watchdog is off.
// RULE_04: The interval setting survives power cycling in nonvolatile bits.
// RULE_05: The reset extension is 0.05 s, 0.2 s, 0.4 s or 0.8 s.
// RULE_06: System reset is active at once when power is applied.
// RULE_07: Reset is active while the primary supply is low and for the delay.
// RULE_08: One variant drives reset as an active-low open-drain pin.
// RULE_09: The other variant drives reset as an active-high pushed output.
// RULE_10: The second-supply fail pin is low while that supply is low.
// RULE_11: The watchdog timeout pin is active-low open-drain when expired.
// RULE_12: The data pin is open-drain and its input is never gated.
// RULE_13: Two nonvolatile bits choose the watchdog period.
// RULE_14: Two power-up bits choose the reset extension delay.
// RULE_15: Comparator inputs are synchronised and delays count clock ticks.
`include "sswd_params.svh"
`default_nettype none

module sswd_top #(
    parameter bit RESET_OPEN_DRAIN = 1'b1,
    parameter int unsigned WDT_CYC_25MS =
        `SSWD_WDT_25MS_NS / `SSWD_CLK_PERIOD_NS,
    // Longer times are whole multiples of the shortest, so scaling the
    // shortest one scales the whole set.
    parameter int unsigned WDT_CYC_200MS =
        WDT_CYC_25MS * (`SSWD_WDT_200MS_NS / `SSWD_WDT_25MS_NS),
    parameter int unsigned WDT_CYC_1400MS =
        WDT_CYC_25MS * (`SSWD_WDT_1400MS_NS / `SSWD_WDT_25MS_NS),
    parameter int unsigned EXT_CYC_50MS =
        (`SSWD_EXT_50MS_NS + `SSWD_CLK_PERIOD_NS - 1) / `SSWD_CLK_PERIOD_NS,
    parameter int unsigned EXT_CYC_200MS =
        EXT_CYC_50MS * (`SSWD_EXT_200MS_NS / `SSWD_EXT_50MS_NS),
    parameter int unsigned EXT_CYC_400MS =
        EXT_CYC_50MS * (`SSWD_EXT_400MS_NS / `SSWD_EXT_50MS_NS),
    parameter int unsigned EXT_CYC_800MS =
        EXT_CYC_50MS * (`SSWD_EXT_800MS_NS / `SSWD_EXT_50MS_NS),
    parameter int CNT_W = `SSWD_CNT_W,
    parameter int DEPTH = `SSWD_SYNC_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic primary_low,
    input wire logic second_supply_sense,
    input wire sswd_pkg::sswd_cfg_s nv_cfg,
    input wire logic nv_cfg_load,
    output logic sys_reset_out,
    output logic sys_reset_oe,
    output logic second_supply_fail_n,
    output logic second_supply_fail_n_oe,
    output logic watchdog_timeout_n,
    output logic watchdog_timeout_n_oe,
    output sswd_pkg::sswd_cfg_s active_cfg
);

    // ------------------------------------------------------------------
    // Interval decoding
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] wdt_limit(input logic [1:0] sel);
        logic [CNT_W-1:0] lim;
        lim = '0;
        unique case (sel)
            `SSWD_WD_SEL_25MS: lim = CNT_W'(WDT_CYC_25MS - 1);
            `SSWD_WD_SEL_200MS: lim = CNT_W'(WDT_CYC_200MS - 1);
            `SSWD_WD_SEL_1400MS: lim = CNT_W'(WDT_CYC_1400MS - 1);
            `SSWD_WD_SEL_OFF: lim = '0;
        endcase
        return lim;
    endfunction : wdt_limit

    function automatic logic [CNT_W-1:0] ext_limit(input logic [1:0] sel);
        logic [CNT_W-1:0] lim;
        lim = '0;
        unique case (sel)
            `SSWD_EXT_SEL_50MS: lim = CNT_W'(EXT_CYC_50MS - 1);
            `SSWD_EXT_SEL_200MS: lim = CNT_W'(EXT_CYC_200MS - 1);
            `SSWD_EXT_SEL_400MS: lim = CNT_W'(EXT_CYC_400MS - 1);
            `SSWD_EXT_SEL_800MS: lim = CNT_W'(EXT_CYC_800MS - 1);
        endcase
        return lim;
    endfunction : ext_limit

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [DEPTH-1:0] plow_sync_q;
    logic [DEPTH-1:0] v2_sync_q;
    logic plow_q;
    logic v2_ok_q;
    logic cfg_loaded_q;
    sswd_pkg::sswd_cfg_s cfg_q;
    sswd_pkg::sswd_cfg_s cfg_d;
    sswd_pkg::sswd_por_e por_q;
    sswd_pkg::sswd_por_e por_d;
    logic [CNT_W-1:0] ext_cnt_q;
    logic [CNT_W-1:0] ext_cnt_d;
    logic [CNT_W-1:0] wdt_cnt_q;
    logic [CNT_W-1:0] wdt_cnt_d;
    logic wdt_exp_q;
    logic wdt_exp_d;
    logic rst_act_q;
    logic v2_fail_q;
    logic wdo_q;
    logic restart_pulse;
    wire plow_f;
    wire v2_f;
    wire [1:0] wd_sel;
    wire [1:0] ext_sel;
    wire [CNT_W-1:0] wd_lim;
    wire [CNT_W-1:0] ex_lim;
    wire wd_off;
    wire ext_done;
    wire wdt_hit;
    wire cfg_take;

    // ------------------------------------------------------------------
    // Bus watcher
    // ------------------------------------------------------------------
    sswd_bus_watch #(
        .DEPTH(DEPTH)
    ) u_bus_watch (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .restart_pulse(restart_pulse),
        .start_seen()
    );

    // ------------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------------
    assign plow_f = (plow_sync_q[DEPTH-1] == plow_sync_q[DEPTH-2])
        ? plow_sync_q[DEPTH-1] : plow_q; // [RULE_15]
    assign v2_f = (v2_sync_q[DEPTH-1] == v2_sync_q[DEPTH-2])
        ? v2_sync_q[DEPTH-1] : v2_ok_q; // [RULE_15]

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            plow_sync_q <= '1;
            v2_sync_q <= '0;
            plow_q <= 1'b1;
            v2_ok_q <= 1'b0;
        end
        else
        begin
            plow_sync_q <= {plow_sync_q[DEPTH-2:0], primary_low};
            v2_sync_q <= {v2_sync_q[DEPTH-2:0], second_supply_sense};
            plow_q <= plow_f;
            v2_ok_q <= v2_f;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile configuration
    // ------------------------------------------------------------------
    // The settings are caught from storage at the first edge after reset
    // release and again whenever storage reports a new value.
    assign cfg_take = !cfg_loaded_q || nv_cfg_load; // [RULE_04]
    assign cfg_d = cfg_take ? nv_cfg : cfg_q;
    assign wd_sel = {cfg_q.watchdog_period_sel_hi,
        cfg_q.watchdog_period_sel_lo}; // [RULE_13]
    assign ext_sel = {cfg_q.reset_delay_sel_hi,
        cfg_q.reset_delay_sel_lo}; // [RULE_14]
    assign wd_lim = wdt_limit(wd_sel); // [RULE_03]
    assign ex_lim = ext_limit(ext_sel); // [RULE_05]
    assign wd_off = wd_sel == `SSWD_WD_SEL_OFF; // [RULE_03]

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_loaded_q <= 1'b0;
            cfg_q <= `SSWD_CFG_RESET;
        end
        else
        begin
            cfg_loaded_q <= 1'b1;
            cfg_q <= cfg_d; // [RULE_04]
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    assign ext_done = ext_cnt_q == ex_lim;

    always_comb
    begin
        por_d = por_q;
        ext_cnt_d = ext_cnt_q;
        unique case (por_q)
            sswd_pkg::POR_HOLD:
            begin
                ext_cnt_d = '0;
                if (!plow_q && cfg_loaded_q)
                begin
                    por_d = sswd_pkg::POR_EXTEND;
                end
            end
            sswd_pkg::POR_EXTEND:
            begin
                if (plow_q)
                begin
                    por_d = sswd_pkg::POR_HOLD; // [RULE_07]
                end
                else if (ext_done)
                begin
                    por_d = sswd_pkg::POR_RUN; // [RULE_07]
                end
                else
                begin
                    ext_cnt_d = CNT_W'(ext_cnt_q + 1'b1); // [RULE_15]
                end
            end
            sswd_pkg::POR_RUN:
            begin
                ext_cnt_d = '0;
                if (plow_q)
                begin
                    por_d = sswd_pkg::POR_HOLD; // [RULE_07]
                end
            end
            default:
            begin
                por_d = sswd_pkg::POR_HOLD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            por_q <= sswd_pkg::POR_HOLD; // [RULE_06]
            ext_cnt_q <= '0;
            rst_act_q <= 1'b1; // [RULE_06]
        end
        else
        begin
            por_q <= por_d;
            ext_cnt_q <= ext_cnt_d;
            rst_act_q <= por_d != sswd_pkg::POR_RUN; // [RULE_07]
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // The count is held clear while the processor is in reset, so the
    // interval starts only once the processor can run.
    assign wdt_hit = wdt_cnt_q == wd_lim;

    always_comb
    begin
        wdt_cnt_d = wdt_cnt_q;
        wdt_exp_d = wdt_exp_q;
        if (rst_act_q || wd_off || restart_pulse || cfg_take)
        begin
            wdt_cnt_d = '0; // [RULE_01]
            wdt_exp_d = 1'b0;
        end
        else if (!wdt_exp_q)
        begin
            if (wdt_hit)
            begin
                wdt_exp_d = 1'b1; // [RULE_02]
            end
            else
            begin
                wdt_cnt_d = CNT_W'(wdt_cnt_q + 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdt_cnt_q <= '0;
            wdt_exp_q <= 1'b0;
        end
        else
        begin
            wdt_cnt_q <= wdt_cnt_d;
            wdt_exp_q <= wdt_exp_d;
        end
    end

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            v2_fail_q <= 1'b1;
            wdo_q <= 1'b0;
        end
        else
        begin
            v2_fail_q <= !v2_ok_q; // [RULE_10]
            wdo_q <= wdt_exp_d; // [RULE_11]
        end
    end

    // The reset pin follows the variant: pulled low or driven high.
    assign sys_reset_out = RESET_OPEN_DRAIN ? 1'b0 : rst_act_q; // [RULE_09]
    assign sys_reset_oe = RESET_OPEN_DRAIN ? rst_act_q : 1'b1; // [RULE_08]
    assign second_supply_fail_n = 1'b0;
    assign second_supply_fail_n_oe = v2_fail_q; // [RULE_10]
    assign watchdog_timeout_n = 1'b0;
    assign watchdog_timeout_n_oe = wdo_q; // [RULE_11]
    // The data pin is never pulled low by this block; its input is free.
    assign sda_out = 1'b0; // [RULE_12]
    assign sda_oe = 1'b0; // [RULE_12]
    assign active_cfg = cfg_q;

endmodule : sswd_top

`default_nettype wire

// ===== verilog/sswd_params.svh
`ifndef SSWD_PARAMS_SVH
`define SSWD_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define SSWD_CLK_PERIOD_NS 5

// ----------------------------------------------------------------------
// Watchdog intervals in nanoseconds
// ----------------------------------------------------------------------
`define SSWD_WDT_25MS_NS 25000000
`define SSWD_WDT_200MS_NS 200000000
`define SSWD_WDT_1400MS_NS 1400000000

// ----------------------------------------------------------------------
// Reset extension delays in nanoseconds
// ----------------------------------------------------------------------
`define SSWD_EXT_50MS_NS 50000000
`define SSWD_EXT_200MS_NS 200000000
`define SSWD_EXT_400MS_NS 400000000
`define SSWD_EXT_800MS_NS 800000000

// ----------------------------------------------------------------------
// Selector encodings
// ----------------------------------------------------------------------
`define SSWD_WD_SEL_25MS 2'h0
`define SSWD_WD_SEL_200MS 2'h1
`define SSWD_WD_SEL_1400MS 2'h2
`define SSWD_WD_SEL_OFF 2'h3
`define SSWD_EXT_SEL_50MS 2'h0
`define SSWD_EXT_SEL_200MS 2'h1
`define SSWD_EXT_SEL_400MS 2'h2
`define SSWD_EXT_SEL_800MS 2'h3

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define SSWD_CNT_W 29
`define SSWD_SYNC_DEPTH 3
`define SSWD_CFG_RESET 4'h0

`endif

// ===== verilog/sswd_pkg.sv
`default_nettype none

package sswd_pkg;

    // ------------------------------------------------------------------
    // Configuration carried from nonvolatile storage
    // ------------------------------------------------------------------
    typedef struct packed {
        logic reset_delay_sel_hi;
        logic watchdog_period_sel_hi;
        logic watchdog_period_sel_lo;
        logic reset_delay_sel_lo;
    } sswd_cfg_s;

    // ------------------------------------------------------------------
    // Supply reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        POR_HOLD,
        POR_EXTEND,
        POR_RUN
    } sswd_por_e;

    // ------------------------------------------------------------------
    // Open-drain or driven pin as value and enable
    // ------------------------------------------------------------------
    typedef struct packed {
        logic value;
        logic oe;
    } sswd_pin_s;

endpackage : sswd_pkg

`default_nettype wire

// ===== verilog/sswd_bus_watch.sv
`include "sswd_params.svh"
`default_nettype none

// ----------------------------------------------------------------------
// Two-wire bus start/stop watcher
// ----------------------------------------------------------------------
module sswd_bus_watch #(
    parameter int DEPTH = `SSWD_SYNC_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic restart_pulse,
    output logic start_seen
);

    logic [DEPTH-1:0] scl_sync_q;
    logic [DEPTH-1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic armed_q;
    logic restart_q;
    wire scl_agree;
    wire sda_agree;
    wire scl_f;
    wire sda_f;
    wire start_cond;
    wire stop_cond;

    // Levels count only once the last two stages agree.
    assign scl_agree = scl_sync_q[DEPTH-1] == scl_sync_q[DEPTH-2];
    assign sda_agree = sda_sync_q[DEPTH-1] == sda_sync_q[DEPTH-2];
    assign scl_f = scl_agree ? scl_sync_q[DEPTH-1] : scl_q;
    assign sda_f = sda_agree ? sda_sync_q[DEPTH-1] : sda_q;

    // Data falling or rising while the clock stays high.
    assign start_cond = scl_prev_q && scl_q && sda_prev_q && !sda_q; // [RULE_01]
    assign stop_cond = scl_prev_q && scl_q && !sda_prev_q && sda_q; // [RULE_01]

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[DEPTH-2:0], scl_in};
            sda_sync_q <= {sda_sync_q[DEPTH-2:0], sda_in}; // [RULE_12]
            scl_q <= scl_f;
            sda_q <= sda_f;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    // A stop restarts the watchdog only after a start has been seen.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            armed_q <= 1'b0;
            restart_q <= 1'b0;
        end
        else
        begin
            restart_q <= stop_cond && armed_q; // [RULE_01]
            if (start_cond)
            begin
                armed_q <= 1'b1;
            end
            else if (stop_cond)
            begin
                armed_q <= 1'b0;
            end
        end
    end

    assign restart_pulse = restart_q;
    assign start_seen = armed_q;

endmodule : sswd_bus_watch

`default_nettype wire

// ===== verif/sswd_checker.sv
`default_nettype none
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module sswd_checker #(
    parameter bit RESET_OPEN_DRAIN = 1'h1,
    parameter int unsigned WDT_CYC_25MS = 40,
    parameter int unsigned EXT_CYC_50MS = 10
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic primary_low,
    input wire logic second_supply_sense,
    input wire sswd_pkg::sswd_cfg_s nv_cfg,
    input wire logic nv_cfg_load,
    input wire logic sys_reset_out,
    input wire logic sys_reset_oe,
    input wire logic second_supply_fail_n,
    input wire logic second_supply_fail_n_oe,
    input wire logic watchdog_timeout_n,
    input wire logic watchdog_timeout_n_oe,
    input wire sswd_pkg::sswd_cfg_s active_cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WD_MIN = WDT_CYC_25MS - 2;
    localparam int EXT_MIN = EXT_CYC_50MS + 1;
    wire logic rst_act = RESET_OPEN_DRAIN ? sys_reset_oe : sys_reset_out;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_start;
        scl_in && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    property p_restart;
        s_start ##[1:30] s_stop |-> ##[1:12] !watchdog_timeout_n_oe;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timeout kept after restart");
    property p_pins;
        !sda_oe && !sda_out && !watchdog_timeout_n && !second_supply_fail_n
            && (RESET_OPEN_DRAIN ? !sys_reset_out : sys_reset_oe);
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin drive levels wrong");
    property p_por;
        $rose(rst_b) |-> rst_act;
    endproperty
    a_por: assert property (p_por)
        else $error("reset not active at power up");
    property p_low;
        primary_low [*8] |=> rst_act;
    endproperty
    a_low: assert property (p_low)
        else $error("reset not active on low supply");
    property p_ext;
        $fell(rst_act) |-> !$past(primary_low, EXT_MIN);
    endproperty
    a_ext: assert property (p_ext)
        else $error("reset released too early");
    property p_fail_lo;
        !second_supply_sense [*8] |=> second_supply_fail_n_oe;
    endproperty
    a_fail_lo: assert property (p_fail_lo)
        else $error("second supply fail not shown");
    property p_hold;
        rst_act [*3] |-> !watchdog_timeout_n_oe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("timeout during system reset");
    property p_expire;
        $rose(watchdog_timeout_n_oe) |-> !$past(rst_act, WD_MIN);
    endproperty
    a_expire: assert property (p_expire)
        else $error("timeout too soon");
    property p_cfg;
        nv_cfg_load |=> active_cfg == $past(nv_cfg);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("configuration not loaded");
endmodule : sswd_checker

bind sswd_top sswd_checker #(
    .RESET_OPEN_DRAIN(RESET_OPEN_DRAIN),
    .WDT_CYC_25MS(WDT_CYC_25MS),
    .EXT_CYC_50MS(EXT_CYC_50MS)
) chk_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .primary_low(primary_low),
    .second_supply_sense(second_supply_sense), .nv_cfg(nv_cfg),
    .nv_cfg_load(nv_cfg_load), .sys_reset_out(sys_reset_out),
    .sys_reset_oe(sys_reset_oe),
    .second_supply_fail_n(second_supply_fail_n),
    .second_supply_fail_n_oe(second_supply_fail_n_oe),
    .watchdog_timeout_n(watchdog_timeout_n),
    .watchdog_timeout_n_oe(watchdog_timeout_n_oe),
    .active_cfg(active_cfg)
);
`default_nettype wire

// ===== verif/sswd_host.sv
`default_nettype none
// ----------------------------------------------------------------------
// Host on the two-wire bus
// ----------------------------------------------------------------------
module sswd_host (
    input wire logic ref_clk,
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end
    task automatic step(input logic c, input logic d);
        repeat (4) @(posedge ref_clk);
        scl_pull <= c;
        sda_pull <= d;
    endtask : step
    // Sends one low bit and a stop, led by a start only when asked.
    task automatic frame(input logic with_start);
        if (with_start)
            step(1'h0, 1'h1);
        else
            step(1'h1, 1'h0);
        step(1'h1, 1'h1);
        step(1'h0, 1'h1);
        step(1'h0, 1'h0);
        repeat (4) @(negedge ref_clk);
    endtask : frame
endmodule : sswd_host
`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        sswd_pkg::sswd_cfg_s cfg;
        int ext;
        int wdt;
    } sswd_row_s;
    sswd_row_s rows [4] = '{'{4'h0, 10, 40}, '{4'h3, 40, 320},
        '{4'hC, 80, 2240}, '{4'hF, 160, 0}};
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic primary_low = 1'h1;
    logic second_supply_sense = 1'h1;
    sswd_pkg::sswd_cfg_s nv_cfg = 4'h0;
    logic nv_cfg_load = 1'h0;
    logic scl_pull;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic sys_reset_out;
    logic sys_reset_oe;
    logic fail_n;
    logic fail_oe;
    logic wdt_n;
    logic wdt_oe;
    sswd_pkg::sswd_cfg_s active_cfg;
    // Both bus lines have pull-ups; any party pulling wins.
    wire logic scl_in = ~scl_pull;
    wire logic sda_in = ~(sda_pull | sda_oe);
    int err_total = 0;
    int n_tests = 0;
    int n;
    logic seen;
    always #2.5 ref_clk = ~ref_clk;

    sswd_top #(
        .WDT_CYC_25MS(40), .EXT_CYC_50MS(10)
    ) dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .primary_low(primary_low),
        .second_supply_sense(second_supply_sense), .nv_cfg(nv_cfg),
        .nv_cfg_load(nv_cfg_load), .sys_reset_out(sys_reset_out),
        .sys_reset_oe(sys_reset_oe), .second_supply_fail_n(fail_n),
        .second_supply_fail_n_oe(fail_oe), .watchdog_timeout_n(wdt_n),
        .watchdog_timeout_n_oe(wdt_oe), .active_cfg(active_cfg)
    );
    sswd_host host_u (
        .ref_clk(ref_clk), .scl_pull(scl_pull), .sda_pull(sda_pull)
    );

    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %s exp %0h got %0h", name, exp, got);
            err_total++;
        end
    endtask : check
    function automatic logic sig(input int s);
        case (s)
            0: return sys_reset_oe;
            1: return wdt_oe;
            default: return fail_oe;
        endcase
    endfunction : sig
    task automatic count_until(input int s, input logic lvl, input int lim,
        output int cnt);
        cnt = 0;
        do
        begin
            @(negedge ref_clk);
            cnt++;
        end
        while (sig(s) !== lvl && cnt < lim);
        n_tests++;
        if (sig(s) !== lvl)
        begin
            $display("MISMATCH wait %0d exp %0b got %0b", s, lvl, sig(s));
            err_total++;
            print_verdict();
        end
    endtask : count_until

    initial
    begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check("por_rst", 1, sys_reset_oe);
        check("por_fail", 1, fail_oe);
        check("por_wdt", 0, wdt_oe);
        check("por_cfg", 0, active_cfg);
        @(posedge ref_clk);
        rst_b <= 1'h1;
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            primary_low <= 1'h1;
            nv_cfg <= rows[i].cfg;
            nv_cfg_load <= 1'h1;
            @(posedge ref_clk);
            nv_cfg_load <= 1'h0;
            count_until(0, 1'h1, 12, n);
            check("cfg", rows[i].cfg, active_cfg);
            @(posedge ref_clk);
            primary_low <= 1'h0;
            count_until(0, 1'h0, rows[i].ext + 12, n);
            seen = n > rows[i].ext && n <= rows[i].ext + 10;
            check("ext", 1, seen);
            check("fail", 0, fail_oe);
            if (rows[i].wdt != 0)
            begin
                count_until(1, 1'h1, rows[i].wdt + 8, n);
                check("wdt", 1, n >= rows[i].wdt - 3);
            end
            else
            begin
                seen = 1'h0;
                repeat (150)
                begin
                    @(negedge ref_clk);
                    seen |= wdt_oe;
                end
                check("wdt_off", 0, seen);
            end
        end
        @(posedge ref_clk);
        rst_b <= 1'h0;
        primary_low <= 1'h1;
        nv_cfg <= 4'hC;
        @(posedge ref_clk);
        rst_b <= 1'h1;
        repeat (2) @(negedge ref_clk);
        check("retain", 4'hC, active_cfg);
        @(posedge ref_clk);
        nv_cfg <= 4'h0;
        nv_cfg_load <= 1'h1;
        @(posedge ref_clk);
        nv_cfg_load <= 1'h0;
        primary_low <= 1'h0;
        count_until(0, 1'h0, 40, n);
        repeat (5) host_u.frame(1'h1);
        check("kick", 0, wdt_oe);
        repeat (3) host_u.frame(1'h0);
        check("no_kick", 1, wdt_oe);
        host_u.frame(1'h1);
        repeat (6) @(negedge ref_clk);
        check("clear", 0, wdt_oe);
        @(posedge ref_clk);
        second_supply_sense <= 1'h0;
        count_until(2, 1'h1, 10, n);
        check("rst_v2", 0, sys_reset_oe);
        @(posedge ref_clk);
        second_supply_sense <= 1'h1;
        count_until(2, 1'h0, 10, n);
        @(posedge ref_clk);
        primary_low <= 1'h1;
        @(posedge ref_clk);
        primary_low <= 1'h0;
        repeat (10) @(negedge ref_clk);
        check("glitch", 0, sys_reset_oe);
        count_until(1, 1'h1, 50, n);
        @(posedge ref_clk);
        primary_low <= 1'h1;
        count_until(0, 1'h1, 10, n);
        repeat (3) @(negedge ref_clk);
        check("wdt_hold", 0, wdt_oe);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
